// >>> hw/dcss_params.svh
// Behaviour
// - Node address range 0-247, 1-255 or 1-247 by protocol option; default 1.
// - Node address writes arriving over the serial link are ignored.
// - Baud select codes 0-5 mean 300 to 9600 bit/s; default code 5.
// - Baud select writes arriving over the serial link are refused.
// - Four commands each own a 2-bit source select: terminal, serial, AND, OR.
// - Source select 1 uses only the control word and ignores the terminal.
// - Freewheel stop is active low on terminal and control-word bit 03.
// - Freewheel: selected input decides in modes 0/1; AND needs both low; OR either.
// - Fast ramp stop is active low on terminal and control-word bit 04.
// - Fast stop: selected input low stops; AND needs both low; OR either.
// - Hold brake is active low on terminal and control-word bit 02.
// - Hold brake: selected input low brakes; AND needs both low; OR either.
// - Run-start combines terminal and serial under its own select, default mode 3.
// - Run-start is active high; AND needs both high; OR needs either high.
`ifndef DCSS_PARAMS_SVH
`define DCSS_PARAMS_SVH

`define DCSS_CLK_HZ          50000000
`define DCSS_CW_HOLD_BRAKE   2
`define DCSS_CW_FREEWHEEL    3
`define DCSS_CW_FAST_STOP    4
`define DCSS_CW_START        6
`define DCSS_CW_VALID        10
`define DCSS_CW_RST          16'h0000
`define DCSS_ADDR_DEF        8'h01
`define DCSS_ADDR_MAX_P0     8'hf7
`define DCSS_ADDR_MIN_P0     8'h00
`define DCSS_ADDR_MAX_P1     8'hff
`define DCSS_ADDR_MIN_P1     8'h01
`define DCSS_ADDR_MAX_P3     8'hf7
`define DCSS_ADDR_MIN_P3     8'h01
`define DCSS_BAUD_DEF        3'h5
`define DCSS_BAUD_MAX        3'h5
`define DCSS_BAUD_300        300
`define DCSS_BAUD_600        600
`define DCSS_BAUD_1200       1200
`define DCSS_BAUD_2400       2400
`define DCSS_BAUD_4800       4800
`define DCSS_BAUD_9600       9600
`define DCSS_BIT_W           18

`endif

// >>> hw/dcss_pkg.sv
package dcss_pkg;
	// Source select encoding shared by all four commands
	typedef enum logic [1:0] {
		DCSS_SRC_TERM = 2'h0,
		DCSS_SRC_SER  = 2'h1,
		DCSS_SRC_AND  = 2'h2,
		DCSS_SRC_OR   = 2'h3
	} dcss_src_e;

	// Protocol option that sets the legal address range
	typedef enum logic [1:0] {
		DCSS_PROTO_0   = 2'h0,
		DCSS_PROTO_1   = 2'h1,
		DCSS_PROTO_BAD = 2'h2,
		DCSS_PROTO_RTU = 2'h3
	} dcss_proto_e;

	// Parameter targeted by a write
	typedef enum logic [2:0] {
		DCSS_PAR_ADDR  = 3'h0,
		DCSS_PAR_BAUD  = 3'h1,
		DCSS_PAR_FREE  = 3'h2,
		DCSS_PAR_FAST  = 3'h3,
		DCSS_PAR_BRAKE = 3'h4,
		DCSS_PAR_START = 3'h5
	} dcss_par_e;

	// Request levels as they arrive (stops and brake active low, start active high)
	typedef struct packed {
		logic freewheel_n;
		logic fast_stop_n;
		logic hold_brake_n;
		logic start;
	} dcss_in_s;

	// Resolved commands, all active high
	typedef struct packed {
		logic freewheel;
		logic fast_stop;
		logic hold_brake_cmd;
		logic start;
	} dcss_cmd_s;

	typedef struct packed {
		dcss_src_e freewheel;
		dcss_src_e fast_stop;
		dcss_src_e hold_brake;
		dcss_src_e start;
	} dcss_sel_s;

	// Parameter write, from the local unit or the serial link
	typedef struct packed {
		logic      wr;
		dcss_par_e sel;
		logic [7:0] data;
	} dcss_wr_s;
endpackage : dcss_pkg

// >>> hw/dcss_top.sv
`include "dcss_params.svh"

module dcss_top (
	// Clock and reset
	input  wire logic                  I_CLK,
	input  wire logic                  I_RST_N,
	// Configuration
	input  wire dcss_pkg::dcss_proto_e I_PROTO,
	// Local operator unit writes
	input  wire dcss_pkg::dcss_wr_s    I_LOC_WR,
	// Serial side: decoded control word and parameter writes
	input  wire logic                  I_CW_STB,
	input  wire logic [15:0]           I_CW,
	input  wire dcss_pkg::dcss_wr_s    I_SER_WR,
	// Digital terminals
	input  wire dcss_pkg::dcss_in_s    I_TERM,
	// Resolved motor commands
	output dcss_pkg::dcss_cmd_s        O_CMD,
	// Configuration readback
	output logic [7:0]                 O_ADDR,
	output logic                       O_ADDR_OK,
	output logic [2:0]                 O_BAUD,
	output logic [`DCSS_BIT_W-1:0]     O_BIT_CYCLES,
	output dcss_pkg::dcss_sel_s        O_SEL,
	// Write outcome pulses and control-word status
	output logic                       O_LOC_REJECT,
	output logic                       O_SER_REFUSED,
	output logic                       O_CW_SEEN
);
	import dcss_pkg::*;

	logic              rst_meta_r;
	logic              rst_n_r;
	logic [7:0]        addr_r;
	logic [2:0]        baud_r;
	dcss_sel_s         sel_r;
	dcss_in_s          ser_r;
	logic              cw_seen_r;
	dcss_cmd_s         cmd_r;
	dcss_cmd_s         cmd_nxt;
	logic              loc_reject_r;
	logic              loc_reject_nxt;
	logic              ser_refused_r;
	logic              ser_refused_nxt;
	logic              addr_ok_r;
	logic [`DCSS_BIT_W-1:0] bit_cycles_r;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// Legal address window for the protocol in force
	function automatic logic addr_legal(input dcss_proto_e proto, input logic [7:0] a);
		logic ok;
		ok = 1'b0;
		unique case (proto)
			DCSS_PROTO_0:   ok = (a >= `DCSS_ADDR_MIN_P0) && (a <= `DCSS_ADDR_MAX_P0);
			DCSS_PROTO_1:   ok = (a >= `DCSS_ADDR_MIN_P1) && (a <= `DCSS_ADDR_MAX_P1);
			DCSS_PROTO_RTU: ok = (a >= `DCSS_ADDR_MIN_P3) && (a <= `DCSS_ADDR_MAX_P3);
			DCSS_PROTO_BAD: ok = 1'b0;
		endcase
		return ok;
	endfunction : addr_legal

	// Clock cycles per bit for a baud code
	function automatic logic [`DCSS_BIT_W-1:0] bit_cycles(input logic [2:0] code);
		int unsigned rate;
		rate = `DCSS_BAUD_9600;
		case (code)
			3'h0:    rate = `DCSS_BAUD_300;
			3'h1:    rate = `DCSS_BAUD_600;
			3'h2:    rate = `DCSS_BAUD_1200;
			3'h3:    rate = `DCSS_BAUD_2400;
			3'h4:    rate = `DCSS_BAUD_4800;
			default: rate = `DCSS_BAUD_9600;
		endcase
		return `DCSS_BIT_W'(`DCSS_CLK_HZ / rate);
	endfunction : bit_cycles

	// A select write is legal for any 2-bit code, so only the upper data bits are checked
	function automatic logic sel_legal(input logic [7:0] d);
		return d[7:2] == 6'h00;
	endfunction : sel_legal

	// Combine one command; requests are first turned active high, then chosen per mode
	function automatic logic resolve(input dcss_src_e mode, input logic term, input logic ser,
	                                 input logic act_low);
		logic t;
		logic s;
		logic r;
		t = act_low ? ~term : term;
		s = act_low ? ~ser : ser;
		r = 1'b0;
		unique case (mode)
			DCSS_SRC_TERM: r = t;
			DCSS_SRC_SER:  r = s;
			DCSS_SRC_AND:  r = t & s;
			DCSS_SRC_OR:   r = t | s;
		endcase
		return r;
	endfunction : resolve

	// Node address: only the local unit may set it
	always_ff @(posedge I_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			addr_r <= `DCSS_ADDR_DEF;
		end else if (I_LOC_WR.wr && I_LOC_WR.sel == DCSS_PAR_ADDR &&
		             addr_legal(I_PROTO, I_LOC_WR.data)) begin
			addr_r <= I_LOC_WR.data;
		end
	end

	// Baud select: only the local unit may set it
	always_ff @(posedge I_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			baud_r <= `DCSS_BAUD_DEF;
		end else if (I_LOC_WR.wr && I_LOC_WR.sel == DCSS_PAR_BAUD &&
		             I_LOC_WR.data <= 8'(`DCSS_BAUD_MAX)) begin
			baud_r <= I_LOC_WR.data[2:0];
		end
	end

	// Source selects: writable from both sides, local wins a same-cycle collision
	always_ff @(posedge I_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			sel_r <= {DCSS_SRC_OR, DCSS_SRC_OR, DCSS_SRC_OR, DCSS_SRC_OR};
		end else if (I_LOC_WR.wr && sel_legal(I_LOC_WR.data)) begin
			case (I_LOC_WR.sel)
				DCSS_PAR_FREE:  sel_r.freewheel  <= dcss_src_e'(I_LOC_WR.data[1:0]);
				DCSS_PAR_FAST:  sel_r.fast_stop  <= dcss_src_e'(I_LOC_WR.data[1:0]);
				DCSS_PAR_BRAKE: sel_r.hold_brake <= dcss_src_e'(I_LOC_WR.data[1:0]);
				DCSS_PAR_START: sel_r.start      <= dcss_src_e'(I_LOC_WR.data[1:0]);
				default:        sel_r            <= sel_r;
			endcase
		end else if (I_SER_WR.wr && sel_legal(I_SER_WR.data)) begin
			case (I_SER_WR.sel)
				DCSS_PAR_FREE:  sel_r.freewheel  <= dcss_src_e'(I_SER_WR.data[1:0]);
				DCSS_PAR_FAST:  sel_r.fast_stop  <= dcss_src_e'(I_SER_WR.data[1:0]);
				DCSS_PAR_BRAKE: sel_r.hold_brake <= dcss_src_e'(I_SER_WR.data[1:0]);
				DCSS_PAR_START: sel_r.start      <= dcss_src_e'(I_SER_WR.data[1:0]);
				default:        sel_r            <= sel_r;
			endcase
		end
	end

	// Write outcome: local writes out of range are rejected
	always_comb begin
		loc_reject_nxt = 1'b0;
		if (I_LOC_WR.wr) begin
			unique case (I_LOC_WR.sel)
				DCSS_PAR_ADDR:  loc_reject_nxt = !addr_legal(I_PROTO, I_LOC_WR.data);
				DCSS_PAR_BAUD:  loc_reject_nxt = I_LOC_WR.data > 8'(`DCSS_BAUD_MAX);
				DCSS_PAR_FREE,
				DCSS_PAR_FAST,
				DCSS_PAR_BRAKE,
				DCSS_PAR_START: loc_reject_nxt = !sel_legal(I_LOC_WR.data);
				default:        loc_reject_nxt = 1'b1;
			endcase
		end
	end

	// Serial writes to address or baud never land; a serial select write lost to a local one also refuses
	always_comb begin
		ser_refused_nxt = 1'b0;
		if (I_SER_WR.wr) begin
			unique case (I_SER_WR.sel)
				DCSS_PAR_ADDR:  ser_refused_nxt = 1'b1;
				DCSS_PAR_BAUD:  ser_refused_nxt = 1'b1;
				DCSS_PAR_FREE,
				DCSS_PAR_FAST,
				DCSS_PAR_BRAKE,
				DCSS_PAR_START: ser_refused_nxt = !sel_legal(I_SER_WR.data) ||
				                                  (I_LOC_WR.wr && sel_legal(I_LOC_WR.data));
				default:        ser_refused_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			loc_reject_r  <= 1'b0;
			ser_refused_r <= 1'b0;
		end else begin
			loc_reject_r  <= loc_reject_nxt;
			ser_refused_r <= ser_refused_nxt;
		end
	end

	// Serial command levels from the last control word marked valid; invalid words leave them held.
	// Reset leaves them all at 0, so stops and brake are requested until the master speaks.
	always_ff @(posedge I_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ser_r     <= '0;
			cw_seen_r <= 1'b0;
		end else if (I_CW_STB && I_CW[`DCSS_CW_VALID]) begin
			ser_r.freewheel_n  <= I_CW[`DCSS_CW_FREEWHEEL];
			ser_r.fast_stop_n  <= I_CW[`DCSS_CW_FAST_STOP];
			ser_r.hold_brake_n <= I_CW[`DCSS_CW_HOLD_BRAKE];
			ser_r.start        <= I_CW[`DCSS_CW_START];
			cw_seen_r          <= 1'b1;
		end
	end

	// Resolution of the four commands
	always_comb begin
		cmd_nxt.freewheel      = resolve(sel_r.freewheel, I_TERM.freewheel_n,
		                                 ser_r.freewheel_n, 1'b1);
		cmd_nxt.fast_stop      = resolve(sel_r.fast_stop, I_TERM.fast_stop_n,
		                                 ser_r.fast_stop_n, 1'b1);
		cmd_nxt.hold_brake_cmd = resolve(sel_r.hold_brake, I_TERM.hold_brake_n,
		                                 ser_r.hold_brake_n, 1'b1);
		cmd_nxt.start          = resolve(sel_r.start, I_TERM.start, ser_r.start, 1'b0);
	end

	// Commands are safe-side after reset: stops and brake requested, no start
	always_ff @(posedge I_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cmd_r <= {1'b1, 1'b1, 1'b1, 1'b0};
		end else begin
			cmd_r <= cmd_nxt;
		end
	end

	// Address may fall out of window when the protocol changes; flag it rather than rewrite it
	always_ff @(posedge I_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			addr_ok_r    <= 1'b0;
			bit_cycles_r <= '0;
		end else begin
			addr_ok_r    <= addr_legal(I_PROTO, addr_r);
			bit_cycles_r <= bit_cycles(baud_r);
		end
	end

	assign O_CMD         = cmd_r;
	assign O_ADDR        = addr_r;
	assign O_ADDR_OK     = addr_ok_r;
	assign O_BAUD        = baud_r;
	assign O_BIT_CYCLES  = bit_cycles_r;
	assign O_SEL         = sel_r;
	assign O_LOC_REJECT  = loc_reject_r;
	assign O_SER_REFUSED = ser_refused_r;
	assign O_CW_SEEN     = cw_seen_r;
endmodule : dcss_top

// >>> verification/dcss_master_model.sv
module dcss_master_model (
	// Clock and request
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_go,
	input  wire logic [15:0] i_word,
	// Decoded control word toward the drive
	output logic             o_stb,
	output logic [15:0]      o_cw
);
	timeunit 1ns;
	timeprecision 1ns;
	// Framing is decoded upstream; the master is assumed to run at the drive's bit rate
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_stb <= 1'b0;
			o_cw  <= 16'h0000;
		end else begin
			o_stb <= i_go;
			// Between words the data is stale, so show the inverse rather than a held copy
			o_cw  <= i_go ? i_word : ~o_cw;
		end
	end
endmodule : dcss_master_model

// >>> verification/dcss_top_properties.sv
module dcss_checker (
	// Clock and reset
	input wire logic                  I_CLK,
	input wire logic                  I_RST_N,
	// Inputs
	input wire dcss_pkg::dcss_proto_e I_PROTO,
	input wire dcss_pkg::dcss_wr_s    I_LOC_WR,
	input wire logic                  I_CW_STB,
	input wire logic [15:0]           I_CW,
	input wire dcss_pkg::dcss_wr_s    I_SER_WR,
	input wire dcss_pkg::dcss_in_s    I_TERM,
	// Outputs
	input wire dcss_pkg::dcss_cmd_s   O_CMD,
	input wire logic [7:0]            O_ADDR,
	input wire logic [2:0]            O_BAUD,
	input wire dcss_pkg::dcss_sel_s   O_SEL,
	input wire logic                  O_LOC_REJECT,
	input wire logic                  O_SER_REFUSED,
	input wire logic                  O_CW_SEEN
);
	import dcss_pkg::*;
	logic [1:0]  up_r;
	logic [15:0] ser_r;
	logic        live;
	// Internal reset trails the pin by two edges, so relations start only after that
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	end
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) ser_r <= 16'h0000;
		else if (I_CW_STB && I_CW[10]) ser_r <= I_CW;
	end
	assign live = (up_r == 2'h3);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	chk_ser_addr_block: assert property (live && I_SER_WR.wr && I_SER_WR.sel == DCSS_PAR_ADDR && !I_LOC_WR.wr
		|=> O_SER_REFUSED && $stable(O_ADDR)) else $error("serial address write taken");
	chk_ser_baud_block: assert property (live && I_SER_WR.wr && I_SER_WR.sel == DCSS_PAR_BAUD && !I_LOC_WR.wr
		|=> O_SER_REFUSED && $stable(O_BAUD)) else $error("serial baud write taken");
	chk_baud_range: assert property (live && I_LOC_WR.wr && I_LOC_WR.sel == DCSS_PAR_BAUD && I_LOC_WR.data > 8'h05
		|=> O_LOC_REJECT && $stable(O_BAUD)) else $error("bad baud code taken");
	chk_addr_store: assert property (live && I_LOC_WR.wr && I_LOC_WR.sel == DCSS_PAR_ADDR && I_PROTO == DCSS_PROTO_RTU
		&& I_LOC_WR.data != 8'h00 && I_LOC_WR.data <= 8'hf7 |=> O_ADDR == $past(I_LOC_WR.data) && !O_LOC_REJECT)
		else $error("legal address not stored");
	chk_free_term: assert property (live && O_SEL.freewheel == DCSS_SRC_TERM
		|=> O_CMD.freewheel == !$past(I_TERM.freewheel_n)) else $error("freewheel terminal mode wrong");
	chk_fast_ser: assert property (live && O_SEL.fast_stop == DCSS_SRC_SER
		|=> O_CMD.fast_stop == !$past(ser_r[4])) else $error("fast stop serial mode wrong");
	chk_brake_and: assert property (live && O_SEL.hold_brake == DCSS_SRC_AND
		|=> O_CMD.hold_brake_cmd == (!$past(I_TERM.hold_brake_n) && !$past(ser_r[2]))) else $error("brake AND wrong");
	chk_start_or: assert property (live && O_SEL.start == DCSS_SRC_OR
		|=> O_CMD.start == ($past(I_TERM.start) || $past(ser_r[6]))) else $error("start OR wrong");
	chk_word_seen: assert property (live && I_CW_STB && I_CW[10] |-> ##[1:2] O_CW_SEEN) else $error("word not seen");
	cover property (O_LOC_REJECT);
	cover property (O_SER_REFUSED);
	cover property (O_CMD.start && O_SEL.start == DCSS_SRC_AND);
endmodule : dcss_checker

bind dcss_top dcss_checker chk_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PROTO(I_PROTO), .I_LOC_WR(I_LOC_WR),
	.I_CW_STB(I_CW_STB), .I_CW(I_CW), .I_SER_WR(I_SER_WR), .I_TERM(I_TERM), .O_CMD(O_CMD), .O_ADDR(O_ADDR),
	.O_BAUD(O_BAUD), .O_SEL(O_SEL), .O_LOC_REJECT(O_LOC_REJECT), .O_SER_REFUSED(O_SER_REFUSED), .O_CW_SEEN(O_CW_SEEN));

// >>> verification/tb_dcss_top.sv
module tb_dcss_top import dcss_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, cw_go = 1'b0, cw_stb, rej, refd, cw_seen, t, s, es, et, addr_ok;
	logic [15:0] cw_word = 16'h0000, cw;
	logic [7:0] addr, ea = 8'h01;
	logic [2:0] baud;
	logic [17:0] bits;
	dcss_proto_e proto = DCSS_PROTO_0;
	dcss_wr_s lw = '0, sw = '0;
	dcss_in_s term = 4'he;
	dcss_cmd_s cmd;
	dcss_sel_s sel;
	int err_total = 0, total_checks = 0;
	int rates[6] = '{300, 600, 1200, 2400, 4800, 9600};
	dcss_proto_e ap[7] = '{DCSS_PROTO_0, DCSS_PROTO_0, DCSS_PROTO_0, DCSS_PROTO_1, DCSS_PROTO_1,
		DCSS_PROTO_RTU, DCSS_PROTO_RTU};
	logic [7:0] ad[7] = '{8'h00, 8'hf7, 8'hf8, 8'h00, 8'hff, 8'h01, 8'hf8};
	logic ao[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

	always #10 clk = ~clk;

	dcss_top dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_PROTO(proto), .I_LOC_WR(lw), .I_CW_STB(cw_stb), .I_CW(cw),
		.I_SER_WR(sw), .I_TERM(term), .O_CMD(cmd), .O_ADDR(addr), .O_ADDR_OK(addr_ok), .O_BAUD(baud), .O_BIT_CYCLES(bits),
		.O_SEL(sel), .O_LOC_REJECT(rej), .O_SER_REFUSED(refd), .O_CW_SEEN(cw_seen));
	dcss_master_model mst_u (.i_clk(clk), .i_rst_n(rst_n), .i_go(cw_go), .i_word(cw_word), .o_stb(cw_stb), .o_cw(cw));

	task automatic chk(input logic [31:0] obs, input logic [31:0] exp);
		total_checks++;
		if (obs !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h, expected %h", $time, obs, exp);
		end
	endtask : chk

	// One parameter write, local or serial; results are visible on return
	task automatic wr(input logic ser, input dcss_par_e p, input logic [7:0] d);
		@(posedge clk);
		if (ser) sw <= {1'b1, p, d};
		else lw <= {1'b1, p, d};
		@(posedge clk);
		sw <= '0;
		lw <= '0;
		#1;
	endtask : wr

	task automatic send(input logic [15:0] w);
		@(posedge clk);
		cw_go <= 1'b1;
		cw_word <= w;
		@(posedge clk);
		cw_go <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : send

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	initial begin
		repeat (3) @(posedge clk);
		chk(addr, 8'h01);
		chk(baud, 3'h5);
		chk(sel, 8'hff);
		chk(cmd, 4'he);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk(bits, 50000000 / 9600);
		$display("Test reset done");
		for (int i = 0; i < 6; i++) begin
			wr(1'b0, DCSS_PAR_BAUD, 8'(i));
			chk(baud, i);
			@(posedge clk);
			#1;
			chk(bits, 50000000 / rates[i]);
		end
		wr(1'b0, DCSS_PAR_BAUD, 8'h06);
		chk(rej, 1'b1);
		wr(1'b1, DCSS_PAR_BAUD, 8'h02);
		chk(refd, 1'b1);
		chk(baud, 3'h5);
		$display("Test baud done");
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			proto <= ap[i];
			wr(1'b0, DCSS_PAR_ADDR, ad[i]);
			if (ao[i]) ea = ad[i];
			chk(addr, ea);
			chk(rej, !ao[i]);
		end
		wr(1'b1, DCSS_PAR_ADDR, 8'h09);
		chk(refd, 1'b1);
		chk(addr, ea);
		chk(addr_ok, 1'b1);
		@(posedge clk);
		proto <= DCSS_PROTO_BAD;
		repeat (2) @(posedge clk);
		#1;
		chk(addr_ok, 1'b0);
		$display("Test address done");
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 4; k++) wr(k[0], dcss_par_e'(3'(k + 2)), 8'(m));
			chk(sel, {4{2'(m)}});
			for (int c = 0; c < 4; c++) begin
				t = c[1];
				s = c[0];
				@(posedge clk);
				term <= {4{t}};
				send({5'h00, 1'b1, 3'h0, s, 1'b0, s, s, s, 2'h0});
				es = m == 0 ? !t : m == 1 ? !s : m == 2 ? !t && !s : !t || !s;
				et = m == 0 ? t : m == 1 ? s : m == 2 ? t && s : t || s;
				chk(cmd, {es, es, es, et});
			end
		end
		send(16'h0000);
		chk(cmd, 4'h1);
		chk(cw_seen, 1'b1);
		$display("Test command select done");
		end_sim;
	end

	initial begin
		#100000;
		err_total++;
		$display("Error at %0t: watchdog expired", $time);
		end_sim;
	end
endmodule : tb_dcss_top
